// [verilog/dma_defines.vh]
// Constants for the multichannel DMA controller.
// Assumes inclusion by bare name from design files.
`ifndef DMA_DEFINES_VH
`define DMA_DEFINES_VH
// Channel, entry and queue counts
`define DMA_NUM_CHAN 64
`define DMA_NUM_QUICK 8
`define DMA_NUM_ENTRY 256
`define DMA_NUM_QUEUE 6
// Hard-wired event positions
`define DMA_CHAN_HOST_BOOT 6'h00
`define DMA_CHAN_TIMER0_LOW 6'h01
// Trigger modes: one array, one frame, whole block
`define DMA_SYNC_ARRAY 2'h0
`define DMA_SYNC_FRAME 2'h1
`define DMA_SYNC_BLOCK 2'h2
// Address modes
`define DMA_ADDR_INCR 1'b0
`define DMA_ADDR_CONST 1'b1
// Entry word field positions (128-bit entry)
`define DMA_F_SRC_LO 0
`define DMA_F_DST_LO 32
`define DMA_F_ACNT_LO 64
`define DMA_F_BCNT_LO 72
`define DMA_F_CCNT_LO 80
`define DMA_F_SIDX_LO 88
`define DMA_F_DIDX_LO 96
`define DMA_F_LINK_LO 104
`define DMA_F_CHAIN_LO 112
`define DMA_F_SYNC_LO 118
`define DMA_F_SMODE 120
`define DMA_F_DMODE 121
`define DMA_F_CHEN 122
`define DMA_F_LINKEN 123
`define DMA_F_IRQEN 124
// Null link index
`define DMA_LINK_NULL 8'hFF
`endif

// [verilog/entry_memory.v]
// Transfer entry memory with registered read data.
// Assumes one write port and one read port on ref_clk.
`timescale 1ns/10ps
module entry_memory #(
    parameter WIDTH = 128,
    parameter DEPTH = 256,
    parameter AW = 8
) (
    // Clock
    input wire ref_clk,
    // Write port
    input wire wr_en,
    input wire [AW-1:0] wr_addr,
    input wire [WIDTH-1:0] wr_data,
    // Read port
    input wire [AW-1:0] rd_addr,
    output reg [WIDTH-1:0] rd_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    always @(posedge ref_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule // entry_memory

// [verilog/dma_controller.v]
// Multichannel DMA controller: events, queues, entry memory, one mover.
// Assumes slave endpoints answer reads and writes with a one-pulse ack.
// Function
// - Three-dimension transfers; one trigger moves array, frame or block.
// - Source and destination indexes step independently.
// - Each endpoint uses increment or constant addressing per entry.
// - Exhausted entry moves on to its linked entry, which runs at once without processor.
// - Completion of one transfer can trigger another channel.
// - 256 entries usable as channel, quick or link entries.
// - 64 channels started by manual write, event or chain.
// - 8 quick channels start on writing the trigger word.
// - Triggers go to 6 queues with programmable priority.
// - Interrupt on completion and on errors; errors recorded.
// - Each queue tracks its watermark against a threshold.
// - Each transfer controller has its own fabric master port.
// - Host boot done event arrives as channel 0, sets flag bit 0.
// - Protection checks use the controller's own privilege.
// - Event to channel mapping is hard-wired.
// - Channels also triggerable by completion of other transfers.
// - Channel 1 triggered by timer 0 low count event.
`timescale 1ns/10ps
`include "dma_defines.vh"
module dma_controller #(
    parameter NCH = 64,
    parameter NQ = 6,
    parameter QDEPTH = 16,
    parameter [3:0] PRIV = 4'h1
) (
    // Clock and reset
    input wire ref_clk,
    input wire rst_b,
    // Synchronization events
    input wire host_boot_done_event,
    input wire timer0_low_count_event,
    input wire [NCH-1:0] periph_event,
    // Software control
    input wire [NCH-1:0] manual_trigger,
    input wire [NCH-1:0] flag_clear,
    input wire [NCH-1:0] miss_clear,
    input wire [3*NCH-1:0] chan_queue_map,
    input wire [7:0] quick_entry_base,
    input wire [3*NQ-1:0] queue_priority,
    input wire [4:0] wm_threshold,
    // Entry write port; writing a quick trigger entry starts it
    input wire entry_wr_en,
    input wire [7:0] entry_wr_addr,
    input wire [127:0] entry_wr_data,
    // Fabric master port
    output reg bus_rd,
    output reg bus_wr,
    output reg [31:0] bus_addr,
    output reg [7:0] bus_wdata,
    output reg [3:0] bus_priv,
    input wire [7:0] bus_rdata,
    input wire bus_ack,
    // Status
    output reg [NCH-1:0] event_flag_register,
    output reg [NCH-1:0] missed_event,
    output reg [NQ-1:0] wm_over,
    output reg [NQ*5-1:0] wm_peak,
    output reg done_irq,
    output reg error_irq,
    output reg [NCH-1:0] done_status
);
    ////////////////////////////////////////////////////////////////////////
    // Event capture
    localparam QW = 3;
    wire [NCH-1:0] raw_event;
    reg [NCH-1:0] chain_event;
    reg [NCH-1:0] submit;
    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1) begin : ev_map
            if (g == 0) begin : boot
                assign raw_event[g] = host_boot_done_event | manual_trigger[g] |
                    chain_event[g];
            end else if (g == 1) begin : tmr
                assign raw_event[g] = timer0_low_count_event | manual_trigger[g] |
                    chain_event[g];
            end else begin : per
                assign raw_event[g] = periph_event[g] | manual_trigger[g] |
                    chain_event[g];
            end
        end
    endgenerate
    wire [NCH-1:0] new_miss = raw_event & event_flag_register & ~submit;
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            event_flag_register <= {NCH{1'b0}};
            missed_event <= {NCH{1'b0}};
        end else begin
            event_flag_register <= (event_flag_register & ~submit & ~flag_clear) |
                raw_event;
            missed_event <= (missed_event & ~miss_clear) | new_miss;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Queues: one channel per cycle submitted, lowest index first
    function [6:0] first_set;
        input [NCH-1:0] v;
        integer i;
        begin
            first_set = 7'h40;
            for (i = NCH - 1; i >= 0; i = i - 1) begin
                if (v[i]) begin
                    first_set = i[6:0];
                end
            end
        end
    endfunction
    reg [7:0] qmem [0:NQ*QDEPTH-1];
    reg [3:0] qwr [0:NQ-1];
    reg [3:0] qrd [0:NQ-1];
    reg [4:0] qcnt [0:NQ-1];
    reg quick_pend;
    reg [7:0] quick_entry;
    wire quick_hit = entry_wr_en && (entry_wr_addr >= quick_entry_base) &&
        (entry_wr_addr < quick_entry_base + 8'h08);
    wire [6:0] pick = first_set(event_flag_register);
    wire [5:0] pick_ch = pick[5:0];
    wire [2:0] pick_q = chan_queue_map[pick_ch*QW +: QW];
    wire [2:0] quick_q = 3'h0;
    reg pop;
    reg [2:0] pop_q;
    integer q;
    always @* begin
        submit = {NCH{1'b0}};
        if (!pick[6] && !quick_pend && qcnt[pick_q] < QDEPTH) begin
            submit[pick_ch] = 1'b1;
        end
    end
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            for (q = 0; q < NQ; q = q + 1) begin
                qwr[q] <= 4'h0;
                qrd[q] <= 4'h0;
                qcnt[q] <= 5'h00;
            end
            quick_pend <= 1'b0;
            quick_entry <= 8'h00;
            wm_peak <= {NQ*5{1'b0}};
            wm_over <= {NQ{1'b0}};
        end else begin
            if (quick_hit) begin
                quick_pend <= 1'b1;
                quick_entry <= entry_wr_addr;
            end
            for (q = 0; q < NQ; q = q + 1) begin
                if (quick_pend && q == quick_q && qcnt[q] < QDEPTH) begin
                    qmem[q*QDEPTH+qwr[q]] <= quick_entry;
                    qwr[q] <= qwr[q] + 4'h1;
                end else if (|submit && q == pick_q) begin
                    qmem[q*QDEPTH+qwr[q]] <= {2'b00, pick_ch};
                    qwr[q] <= qwr[q] + 4'h1;
                end
                if (pop && q == pop_q) begin
                    qrd[q] <= qrd[q] + 4'h1;
                end
                qcnt[q] <= qcnt[q] + (((quick_pend && q == quick_q && qcnt[q] < QDEPTH) ||
                    (|submit && !quick_pend && q == pick_q)) ? 5'h01 : 5'h00) -
                    ((pop && q == pop_q) ? 5'h01 : 5'h00);
                if (qcnt[q] > wm_peak[q*5 +: 5]) begin
                    wm_peak[q*5 +: 5] <= qcnt[q];
                end
                if (qcnt[q] > wm_threshold) begin
                    wm_over[q] <= 1'b1;
                end
            end
            if (quick_pend && qcnt[quick_q] < QDEPTH && !quick_hit) begin
                quick_pend <= 1'b0;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Queue arbiter: lowest priority value wins
    reg [2:0] best_q;
    reg best_ok;
    integer k;
    always @* begin
        best_q = 3'h0;
        best_ok = 1'b0;
        for (k = 0; k < NQ; k = k + 1) begin
            if (qcnt[k] != 5'h00 && (!best_ok ||
                queue_priority[k*3 +: 3] < queue_priority[best_q*3 +: 3])) begin
                best_q = k[2:0];
                best_ok = 1'b1;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Entry memory
    reg [7:0] mem_rd_addr;
    reg upd_wr;
    reg [127:0] upd_data;
    wire [127:0] entry;
    wire mw_en = entry_wr_en | upd_wr;
    wire [7:0] mw_addr = entry_wr_en ? entry_wr_addr : mem_rd_addr;
    wire [127:0] mw_data = entry_wr_en ? entry_wr_data : upd_data;
    entry_memory #(.WIDTH(128), .DEPTH(256), .AW(8)) u_mem (
        .ref_clk(ref_clk),
        .wr_en(mw_en),
        .wr_addr(mw_addr),
        .wr_data(mw_data),
        .rd_addr(mem_rd_addr),
        .rd_data(entry)
    );
    ////////////////////////////////////////////////////////////////////////
    // Transfer engine
    localparam S_IDLE = 7'h01, S_FETCH = 7'h02, S_LOAD = 7'h04, S_READ = 7'h08;
    localparam S_WRITE = 7'h10, S_STEP = 7'h20, S_DONE = 7'h40;
    reg [6:0] state;
    reg [127:0] cur;
    reg [31:0] src, dst, src_row, dst_row;
    reg [7:0] acnt, bcnt, ccnt;
    reg [7:0] data_hold;
    reg [5:0] cur_ch;
    reg frame_end;
    integer m;
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= S_IDLE;
            pop <= 1'b0;
            pop_q <= 3'h0;
            mem_rd_addr <= 8'h00;
            upd_wr <= 1'b0;
            upd_data <= 128'h0;
            cur <= 128'h0;
            src <= 32'h0; dst <= 32'h0; src_row <= 32'h0; dst_row <= 32'h0;
            acnt <= 8'h00; bcnt <= 8'h00; ccnt <= 8'h00;
            data_hold <= 8'h00;
            cur_ch <= 6'h00;
            frame_end <= 1'b0;
            bus_rd <= 1'b0; bus_wr <= 1'b0;
            bus_addr <= 32'h0; bus_wdata <= 8'h00;
            bus_priv <= 4'h0;
            chain_event <= {NCH{1'b0}};
            done_irq <= 1'b0; error_irq <= 1'b0;
            done_status <= {NCH{1'b0}};
        end else begin
            pop <= 1'b0;
            upd_wr <= 1'b0;
            chain_event <= {NCH{1'b0}};
            done_irq <= 1'b0;
            error_irq <= |new_miss;
            case (state)
                S_IDLE: begin
                    if (best_ok && !pop) begin
                        mem_rd_addr <= qmem[best_q*QDEPTH+qrd[best_q]];
                        cur_ch <= qmem[best_q*QDEPTH+qrd[best_q]][5:0];
                        pop <= 1'b1;
                        pop_q <= best_q;
                        state <= S_FETCH;
                    end
                end
                S_FETCH: state <= S_LOAD;
                S_LOAD: begin
                    cur <= entry;
                    src <= entry[`DMA_F_SRC_LO +: 32];
                    dst <= entry[`DMA_F_DST_LO +: 32];
                    src_row <= entry[`DMA_F_SRC_LO +: 32];
                    dst_row <= entry[`DMA_F_DST_LO +: 32];
                    acnt <= entry[`DMA_F_ACNT_LO +: 8];
                    bcnt <= entry[`DMA_F_BCNT_LO +: 8];
                    ccnt <= entry[`DMA_F_CCNT_LO +: 8];
                    frame_end <= 1'b0;
                    state <= S_READ;
                end
                S_READ: begin
                    bus_rd <= 1'b1;
                    bus_priv <= PRIV;
                    bus_addr <= src;
                    if (bus_ack && bus_rd) begin
                        bus_rd <= 1'b0;
                        data_hold <= bus_rdata;
                        state <= S_WRITE;
                    end
                end
                S_WRITE: begin
                    bus_wr <= 1'b1;
                    bus_addr <= dst;
                    bus_wdata <= data_hold;
                    if (bus_ack && bus_wr) begin
                        bus_wr <= 1'b0;
                        state <= S_STEP;
                    end
                end
                S_STEP: begin
                    if (cur[`DMA_F_SMODE] == `DMA_ADDR_INCR) src <= src + 32'h1;
                    if (cur[`DMA_F_DMODE] == `DMA_ADDR_INCR) dst <= dst + 32'h1;
                    state <= S_READ;
                    if (acnt <= 8'h01) begin
                        acnt <= cur[`DMA_F_ACNT_LO +: 8];
                        src <= src_row + {{24{cur[`DMA_F_SIDX_LO+7]}}, cur[`DMA_F_SIDX_LO +: 8]};
                        dst <= dst_row + {{24{cur[`DMA_F_DIDX_LO+7]}}, cur[`DMA_F_DIDX_LO +: 8]};
                        src_row <= src_row + {{24{cur[`DMA_F_SIDX_LO+7]}}, cur[`DMA_F_SIDX_LO +: 8]};
                        dst_row <= dst_row + {{24{cur[`DMA_F_DIDX_LO+7]}}, cur[`DMA_F_DIDX_LO +: 8]};
                        if (bcnt <= 8'h01) begin
                            bcnt <= cur[`DMA_F_BCNT_LO +: 8];
                            ccnt <= ccnt - 8'h01;
                            frame_end <= 1'b1;
                            if (ccnt <= 8'h01 || cur[`DMA_F_SYNC_LO +: 2] != `DMA_SYNC_BLOCK)
                                state <= S_DONE;
                        end else begin
                            bcnt <= bcnt - 8'h01;
                            if (cur[`DMA_F_SYNC_LO +: 2] == `DMA_SYNC_ARRAY)
                                state <= S_DONE;
                        end
                    end else begin
                        acnt <= acnt - 8'h01;
                    end
                end
                S_DONE: begin
                    upd_wr <= 1'b1;
                    upd_data <= cur;
                    upd_data[`DMA_F_SRC_LO +: 32] <= src_row;
                    upd_data[`DMA_F_DST_LO +: 32] <= dst_row;
                    upd_data[`DMA_F_BCNT_LO +: 8] <= bcnt;
                    upd_data[`DMA_F_CCNT_LO +: 8] <= ccnt;
                    if (ccnt == 8'h00 || (frame_end && ccnt <= 8'h01 &&
                        cur[`DMA_F_SYNC_LO +: 2] == `DMA_SYNC_BLOCK)) begin
                        if (cur[`DMA_F_LINKEN] &&
                            cur[`DMA_F_LINK_LO +: 8] != `DMA_LINK_NULL) begin
                            mem_rd_addr <= cur[`DMA_F_LINK_LO +: 8];
                            upd_wr <= 1'b0;
                            state <= S_FETCH;
                        end else begin
                            state <= S_IDLE;
                        end
                        if (cur[`DMA_F_CHEN]) chain_event[cur[`DMA_F_CHAIN_LO +: 6]] <= 1'b1;
                        if (cur[`DMA_F_IRQEN]) done_irq <= 1'b1;
                        done_status[cur_ch] <= 1'b1;
                    end else begin
                        state <= S_IDLE;
                    end
                    for (m = 0; m < NCH; m = m + 1) begin
                        if (flag_clear[m]) done_status[m] <= 1'b0;
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end
endmodule // dma_controller

// [dv/dma_monitor.sv]
// Checker for the DMA controller ports: flags, misses, bus handshake.
// Assumes binding onto dma_controller; one clock domain.
`timescale 1ns/10ps
module dma_monitor #(
    parameter NCH = 64,
    parameter NQ = 6,
    parameter QDEPTH = 16,
    parameter [3:0] PRIV = 4'h1
) (
    // Clock and reset
    input wire ref_clk,
    input wire rst_b,
    // Events
    input wire host_boot_done_event,
    input wire timer0_low_count_event,
    input wire [NCH-1:0] periph_event,
    // Fabric port
    input wire bus_rd,
    input wire bus_wr,
    input wire [31:0] bus_addr,
    input wire [7:0] bus_wdata,
    input wire [3:0] bus_priv,
    input wire [7:0] bus_rdata,
    input wire bus_ack,
    // Status
    input wire [NCH-1:0] event_flag_register,
    input wire [NCH-1:0] missed_event,
    input wire done_irq,
    input wire error_irq
);
    reg [7:0] last_rd;
    reg [NCH-1:0] hit;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            last_rd <= 8'h00;
            hit <= {NCH{1'b0}};
        end else begin
            if (bus_rd && bus_ack) begin
                last_rd <= bus_rdata;
            end
            // Lowest flagged channel may be submitted in this very cycle
            hit <= periph_event & event_flag_register & ~{{(NCH-2){1'b0}}, 2'b11} &
                ~(event_flag_register & (~event_flag_register + {{(NCH-1){1'b0}}, 1'b1}));
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    property p_flag0; host_boot_done_event |=> event_flag_register[0]; endproperty
    a_flag0: assert property (p_flag0) else $error("host boot event lost");
    property p_flag1; timer0_low_count_event |=> event_flag_register[1]; endproperty
    a_flag1: assert property (p_flag1) else $error("timer event lost");
    property p_miss; |hit |-> (missed_event & hit) == hit; endproperty
    a_miss: assert property (p_miss) else $error("missed event not kept");
    property p_err; |hit |-> ##[0:1] error_irq; endproperty
    a_err: assert property (p_err) else $error("no error pulse on miss");
    property p_hold_rd; bus_rd && !bus_ack |=> bus_rd && $stable(bus_addr); endproperty
    a_hold_rd: assert property (p_hold_rd) else $error("read dropped early");
    property p_hold_wr;
        bus_wr && !bus_ack |=> bus_wr && $stable(bus_addr) && $stable(bus_wdata);
    endproperty
    a_hold_wr: assert property (p_hold_wr) else $error("write dropped early");
    property p_priv; bus_rd || bus_wr |-> bus_priv == PRIV; endproperty
    a_priv: assert property (p_priv) else $error("foreign privilege used");
    property p_excl; !(bus_rd && bus_wr); endproperty
    a_excl: assert property (p_excl) else $error("read and write together");
    property p_rd_wr; bus_rd && bus_ack |-> ##[1:6] bus_wr; endproperty
    a_rd_wr: assert property (p_rd_wr) else $error("read not followed by write");
    property p_wdata; $rose(bus_wr) |-> bus_wdata == last_rd; endproperty
    a_wdata: assert property (p_wdata) else $error("write data differs from read");
    c_wr: cover property (bus_wr && bus_ack);
    c_miss: cover property (|hit);
    c_done: cover property (done_irq);
endmodule // dma_monitor
bind dma_controller dma_monitor #(.NCH(NCH), .NQ(NQ), .QDEPTH(QDEPTH), .PRIV(PRIV)) i_mon (
    .ref_clk(ref_clk), .rst_b(rst_b), .host_boot_done_event(host_boot_done_event),
    .timer0_low_count_event(timer0_low_count_event), .periph_event(periph_event),
    .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_priv(bus_priv), .bus_rdata(bus_rdata), .bus_ack(bus_ack),
    .event_flag_register(event_flag_register), .missed_event(missed_event),
    .done_irq(done_irq), .error_irq(error_irq));

// [dv/slave_memory.sv]
// Byte slave endpoint behind the switch fabric, with settable stall.
// Assumes requests held until a one-cycle ack.
`timescale 1ns/10ps
module slave_memory (
    input wire ref_clk,
    input wire rst_b,
    input wire [3:0] stall,
    input wire bus_rd,
    input wire bus_wr,
    input wire [31:0] bus_addr,
    input wire [7:0] bus_wdata,
    output wire [7:0] bus_rdata,
    output reg bus_ack
);
    reg [7:0] mem [0:4095];
    reg [7:0] rd_q;
    reg [3:0] cnt;
    integer i;
    initial begin
        for (i = 0; i < 4096; i = i + 1) begin
            mem[i] = i[7:0] ^ 8'hA5;
        end
    end
    // Data stands only in the ack cycle
    assign bus_rdata = bus_ack ? rd_q : ~rd_q;
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            bus_ack <= 1'b0;
            cnt <= 4'h0;
            rd_q <= 8'h00;
        end else begin
            bus_ack <= 1'b0;
            if ((bus_rd || bus_wr) && !bus_ack) begin
                if (cnt >= stall) begin
                    bus_ack <= 1'b1;
                    cnt <= 4'h0;
                    if (bus_wr) begin
                        mem[bus_addr[11:0]] <= bus_wdata;
                    end else begin
                        rd_q <= mem[bus_addr[11:0]];
                    end
                end else begin
                    cnt <= cnt + 4'h1;
                end
            end
        end
    end
endmodule // slave_memory

// [dv/multichannel_dma_controller_tb.sv]
// Testbench: quick-channel moves against a slave memory, then events.
// Assumes quick entries from 8'h10 and zeroed regular entries.
`timescale 1ns/10ps
`include "dma_defines.vh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
    $display("Error %0t: got %h exp %h", $time, g, e); end end
module multichannel_dma_controller_tb;
    typedef struct {int ac, bc, si, di, sy, sm, dm, wt, nar;} row_t;
    row_t rows [5] = '{'{5, 1, 8, 4, 0, 0, 0, 0, 1}, '{3, 2, 8, 4, 1, 0, 0, 2, 2},
        '{2, 3, 4, 8, 2, 0, 0, 0, 3},
        '{4, 1, 0, 0, 0, 1, 0, 3, 1}, '{4, 1, 0, 0, 0, 0, 1, 0, 1}};
    reg ref_clk = 0, rst_b = 0, hb = 0, tm = 0, we = 0;
    reg [63:0] pe = 0, fc = 0, mc = 0;
    reg [7:0] wa = 0;
    reg [127:0] wd = 0;
    reg [3:0] stall = 0;
    wire rd, wr, ack, done_irq, error_irq;
    wire [31:0] addr;
    wire [7:0] wdat, rdat;
    wire [3:0] priv;
    wire [63:0] flags, missed, dstat;
    wire [5:0] wmo;
    wire [29:0] wmp;
    reg [7:0] exp_mem [0:4095];
    int error_cnt = 0, tests_run = 0, cyc = 0, r, a, b, k, s, d;
    always #2 ref_clk = ~ref_clk;
    dma_controller i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .host_boot_done_event(hb),
        .timer0_low_count_event(tm), .periph_event(pe), .manual_trigger(64'h0000_0000_0000_0000),
        .flag_clear(fc), .miss_clear(mc), .chan_queue_map(192'h0), .quick_entry_base(8'h10),
        .queue_priority(18'h0_0000), .wm_threshold(5'h1F), .entry_wr_en(we),
        .entry_wr_addr(wa), .entry_wr_data(wd), .bus_rd(rd), .bus_wr(wr), .bus_addr(addr),
        .bus_wdata(wdat), .bus_priv(priv), .bus_rdata(rdat), .bus_ack(ack),
        .event_flag_register(flags), .missed_event(missed), .wm_over(wmo), .wm_peak(wmp),
        .done_irq(done_irq), .error_irq(error_irq), .done_status(dstat));
    slave_memory i_slave (.ref_clk(ref_clk), .rst_b(rst_b), .stall(stall), .bus_rd(rd),
        .bus_wr(wr), .bus_addr(addr), .bus_wdata(wdat), .bus_rdata(rdat), .bus_ack(ack));
    ////////////////////////////////////////////////////////////////////////////////
    task close_out;
        $display("Counts: %0d compared, %0d mismatched", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 6000) begin
            error_cnt++;
            $display("Error %0t: timeout", $time);
            close_out;
        end
    end
    task step(int n);
        repeat (n) @(negedge ref_clk);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        for (k = 0; k < 4096; k++) exp_mem[k] = k[7:0] ^ 8'hA5;
        step(20);
        rst_b = 1;
        `CHK(flags, 64'h0000_0000_0000_0000)
        `CHK(missed, 64'h0000_0000_0000_0000)
        // Regular entries 0 to 7 start zeroed
        wd = 0;
        we = 1;
        for (k = 0; k < 8; k++) begin
            wa = k[7:0];
            step(1);
        end
        we = 0;
        for (r = 0; r < 5; r++) begin
            s = 'h100 + r * 'h40;
            d = 'h400 + r * 'h40;
            wd = 0;
            wd[`DMA_F_SRC_LO +: 32] = s;
            wd[`DMA_F_DST_LO +: 32] = d;
            wd[`DMA_F_ACNT_LO +: 8] = rows[r].ac;
            wd[`DMA_F_BCNT_LO +: 8] = rows[r].bc;
            wd[`DMA_F_CCNT_LO +: 8] = 1;
            wd[`DMA_F_SIDX_LO +: 8] = rows[r].si;
            wd[`DMA_F_DIDX_LO +: 8] = rows[r].di;
            wd[`DMA_F_LINK_LO +: 8] = `DMA_LINK_NULL;
            wd[`DMA_F_SYNC_LO +: 2] = rows[r].sy;
            wd[`DMA_F_SMODE] = rows[r].sm;
            wd[`DMA_F_DMODE] = rows[r].dm;
            wd[`DMA_F_IRQEN] = 1'b1;
            stall = rows[r].wt;
            for (b = 0; b < rows[r].nar; b++) begin
                for (a = 0; a < rows[r].ac; a++) begin
                    exp_mem[d + (rows[r].dm ? 0 : b * rows[r].di + a)] =
                        exp_mem[s + (rows[r].sm ? 0 : b * rows[r].si + a)];
                end
            end
            wa = 8'h10 + r[7:0];
            we = 1;
            step(1);
            we = 0;
            for (k = 0; k < 500 && done_irq !== 1'b1; k++) step(1);
            `CHK(done_irq, 1'b1)
            step(4);
            for (k = d; k < d + 'h40; k++) `CHK(i_slave.mem[k], exp_mem[k])
            $display("Done: move row %0d", r);
        end
        `CHK(wmp[4:0], 5'h01)
        `CHK(wmo, 6'h00)
        // Quick entry whose completion chains channel 6
        wd = 0;
        wd[`DMA_F_ACNT_LO +: 8] = 1;
        wd[`DMA_F_BCNT_LO +: 8] = 1;
        wd[`DMA_F_CCNT_LO +: 8] = 1;
        wd[`DMA_F_LINK_LO +: 8] = `DMA_LINK_NULL;
        wd[`DMA_F_CHAIN_LO +: 6] = 6;
        wd[`DMA_F_CHEN] = 1'b1;
        wa = 8'h17;
        we = 1;
        step(1);
        we = 0;
        for (k = 0; k < 500 && flags[6] !== 1'b1; k++) step(1);
        `CHK(flags[6], 1'b1)
        `CHK(dstat, 64'h0000_0000_009F_0000)
        $display("Done: chained channel");
        step(20);
        hb = 1;
        step(1);
        hb = 0;
        `CHK(flags[0], 1'b1)
        fc[0] = 1;
        step(1);
        fc[0] = 0;
        tm = 1;
        step(1);
        tm = 0;
        `CHK(flags[1], 1'b1)
        $display("Done: fixed events");
        step(20);
        // Channel 4 is picked first, so the flag of 5 stays set
        pe[5:4] = 2'b11;
        step(2);
        pe[5:4] = 2'b00;
        step(1);
        `CHK(missed[5], 1'b1)
        `CHK(missed[4], 1'b0)
        mc[5] = 1;
        step(1);
        mc[5] = 0;
        step(1);
        `CHK(missed[5], 1'b0)
        $display("Done: missed event");
        step(50);
        close_out;
    end
endmodule // multichannel_dma_controller_tb
